// ---- verilog/ppsp_pkg.sv ----
/*
  Constants shared by the status packet framer: packet length, byte offsets
  of each field, field widths and the buffer-select encoding.
  Assumes a single system clock domain.
*/
package ppsp_pkg;

  localparam int unsigned PKT_LEN = 64;
  localparam int unsigned IDX_W = 6;

  // byte offsets within the packet
  localparam logic [5:0] OFS_FAST = 6'h00;
  localparam logic [5:0] OFS_SLOW = 6'h04;
  localparam logic [5:0] OFS_MS = 6'h09;
  localparam logic [5:0] OFS_T100 = 6'h0a;
  localparam logic [5:0] OFS_SERIAL = 6'h0e;
  localparam logic [5:0] OFS_TEMP = 6'h16;
  localparam logic [5:0] OFS_GP = 6'h18;
  localparam logic [5:0] OFS_LAST = 6'h3f;

  // field widths
  localparam int unsigned CNT_W = 32;
  localparam int unsigned MS_W = 7;
  localparam int unsigned T100_W = 24;
  localparam int unsigned TEMP_W = 8;

  // count-buffer source selection
  typedef enum logic [1:0] {
    PPSP_BUF_SW_A = 2'h0,
    PPSP_BUF_SW_B = 2'h1,
    PPSP_BUF_HW = 2'h2,
    PPSP_BUF_NONE = 2'h3
  } ppsp_buf_mode_t;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage : ppsp_pkg

// ---- verilog/ppsp_byte_mux.sv ----
/*
  Combinational byte selector: returns the packet byte at a given index from
  the captured field values.
  Assumes the fields are held stable by the caller while the index walks.
*/
`timescale 1ns/100ps
module ppsp_byte_mux
  import ppsp_pkg::*;
(
  input wire logic [ppsp_pkg::IDX_W-1:0] i_idx,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_fast,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_slow,
  input wire logic [ppsp_pkg::MS_W-1:0] i_ms,
  input wire logic [ppsp_pkg::T100_W-1:0] i_t100,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_serial,
  input wire logic [ppsp_pkg::TEMP_W-1:0] i_temp,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_gp,
  output logic [7:0] o_byte
);

  // byte k of a word, least significant byte first
  function automatic logic [7:0] ppsp_lane(input logic [31:0] w, input logic [5:0] k);
    logic [1:0] lane;
    lane = k[1:0];
    return w[{lane, 3'b000} +: 8];
  endfunction : ppsp_lane

  logic [5:0] rel;

  always_comb
  begin
    o_byte = BYTE_ZERO; // [RULE8]
    rel = 6'h00;
    if (i_idx >= OFS_FAST && i_idx < OFS_SLOW)
    begin
      rel = i_idx - OFS_FAST;
      o_byte = ppsp_lane(i_fast, rel); // [RULE1]
    end
    else if (i_idx >= OFS_SLOW && i_idx < OFS_SLOW + 6'h04)
    begin
      rel = i_idx - OFS_SLOW;
      o_byte = ppsp_lane(i_slow, rel); // [RULE2]
    end
    else if (i_idx == OFS_MS)
    begin
      o_byte = {1'b0, i_ms}; // [RULE3]
    end
    else if (i_idx >= OFS_T100 && i_idx < OFS_T100 + 6'h03)
    begin
      rel = i_idx - OFS_T100;
      o_byte = ppsp_lane({8'h00, i_t100}, rel); // [RULE3]
    end
    else if (i_idx >= OFS_SERIAL && i_idx < OFS_SERIAL + 6'h04)
    begin
      rel = i_idx - OFS_SERIAL;
      o_byte = ppsp_lane(i_serial, rel); // [RULE4]
    end
    else if (i_idx == OFS_TEMP)
    begin
      o_byte = i_temp; // [RULE5]
    end
    else if (i_idx >= OFS_GP && i_idx < OFS_GP + 6'h04)
    begin
      rel = i_idx - OFS_GP;
      o_byte = ppsp_lane(i_gp, rel); // [RULE6]
    end
  end

endmodule : ppsp_byte_mux

// ---- verilog/ppsp_framer.sv ----
/*
  Status packet framer: on a request, captures counts, time, serial number,
  temperature and the general-purpose counter, then streams a fixed 64-byte
  packet out one byte per accepted valid/ready beat.
  Assumes the link side drives i_ready from the same clock; the hardware
  buffer-select pin is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps
// Operation
// (RULE1) bytes 0-3 carry the fast count of the chosen buffer, LSB first.
// (RULE2) bytes 4-7 carry the slow count of the same buffer, LSB first.
// (RULE3) byte 9 holds milliseconds 0-99; bytes 10-12 hold 100 ms units.
// (RULE4) bytes 14-17 carry the 32-bit serial number, LSB first.
// (RULE5) byte 22 holds signed board temperature, one degree per count.
// (RULE6) bytes 24-27 carry the general-purpose counter, LSB first.
// (RULE7) host field picks buffer A, buffer B, or the hardware select pin.
// (RULE8) packet is 64 bytes; every unassigned byte reads as zero.
module ppsp_framer
  import ppsp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire ppsp_pkg::ppsp_buf_mode_t i_buf_mode,
  input wire logic i_hw_buf_sel,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_fast_a,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_slow_a,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_fast_b,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_slow_b,
  input wire logic [ppsp_pkg::MS_W-1:0] i_acc_ms,
  input wire logic [ppsp_pkg::T100_W-1:0] i_acc_t100,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_serial,
  input wire logic [ppsp_pkg::TEMP_W-1:0] i_temp,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_gp_count,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_first,
  output logic o_last,
  output logic o_busy
);

  typedef enum logic [1:0] {
    PPSP_IDLE,
    PPSP_PREP,
    PPSP_SEND
  } ppsp_state_t;

  typedef struct packed {
    ppsp_state_t state;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
    logic valid;
    logic first;
    logic last;
    logic hw_s1;
    logic hw_s2;
    logic [CNT_W-1:0] fast;
    logic [CNT_W-1:0] slow;
    logic [MS_W-1:0] ms;
    logic [T100_W-1:0] t100;
    logic [CNT_W-1:0] serial;
    logic [TEMP_W-1:0] temp;
    logic [CNT_W-1:0] gp;
  } ppsp_regs_t;

  ppsp_regs_t r_q;
  ppsp_regs_t r_d;
  logic [IDX_W-1:0] mux_idx;
  logic [7:0] mux_byte;
  logic pick_b;

  // byte index presented to the selector: first byte, else the one after
  assign mux_idx = (r_q.state == PPSP_PREP) ? OFS_FAST : IDX_W'(r_q.idx + 6'h01);

  ppsp_byte_mux u_mux (
    .i_idx(mux_idx),
    .i_fast(r_q.fast),
    .i_slow(r_q.slow),
    .i_ms(r_q.ms),
    .i_t100(r_q.t100),
    .i_serial(r_q.serial),
    .i_temp(r_q.temp),
    .i_gp(r_q.gp),
    .o_byte(mux_byte)
  );

  // buffer choice at request time; unused code falls back to buffer A
  always_comb
  begin
    pick_b = 1'b0;
    unique case (i_buf_mode)
      PPSP_BUF_SW_A: pick_b = 1'b0; // [RULE7]
      PPSP_BUF_SW_B: pick_b = 1'b1; // [RULE7]
      PPSP_BUF_HW: pick_b = r_q.hw_s2; // [RULE7]
      PPSP_BUF_NONE: pick_b = 1'b0;
    endcase
  end

  always_comb
  begin
    r_d = r_q;
    r_d.hw_s1 = i_hw_buf_sel;
    r_d.hw_s2 = r_q.hw_s1;
    unique case (r_q.state)
      PPSP_IDLE:
      begin
        if (i_req)
        begin
          // snapshot keeps all multi-byte fields coherent across the packet
          r_d.fast = pick_b ? i_fast_b : i_fast_a; // [RULE1]
          r_d.slow = pick_b ? i_slow_b : i_slow_a; // [RULE2]
          r_d.ms = i_acc_ms; // [RULE3]
          r_d.t100 = i_acc_t100; // [RULE3]
          r_d.serial = i_serial; // [RULE4]
          r_d.temp = i_temp; // [RULE5]
          r_d.gp = i_gp_count; // [RULE6]
          r_d.state = PPSP_PREP;
        end
      end
      PPSP_PREP:
      begin
        r_d.idx = OFS_FAST;
        r_d.data = mux_byte;
        r_d.valid = 1'b1;
        r_d.first = 1'b1;
        r_d.last = 1'b0;
        r_d.state = PPSP_SEND;
      end
      PPSP_SEND:
      begin
        if (i_ready)
        begin
          r_d.first = 1'b0;
          if (r_q.last)
          begin
            r_d.valid = 1'b0;
            r_d.last = 1'b0;
            r_d.data = BYTE_ZERO;
            r_d.idx = OFS_FAST;
            r_d.state = PPSP_IDLE;
          end
          else
          begin
            r_d.idx = mux_idx;
            r_d.data = mux_byte;
            r_d.last = (mux_idx == OFS_LAST); // [RULE8]
          end
        end
      end
      // unused state code: drop back to idle
      default:
      begin
        r_d.state = PPSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      r_q <= '0;
      r_q.state <= PPSP_IDLE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_valid = r_q.valid;
  assign o_data = r_q.data;
  assign o_first = r_q.first;
  assign o_last = r_q.last;
  assign o_busy = (r_q.state != PPSP_IDLE);

endmodule : ppsp_framer

// ---- tb/ppsp_monitor.sv ----
/* checker for the status packet framer; bound onto ppsp_framer ports */
`timescale 1ns/100ps
module ppsp_monitor
  import ppsp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire ppsp_pkg::ppsp_buf_mode_t i_buf_mode,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_fast_a,
  input wire logic [ppsp_pkg::CNT_W-1:0] i_fast_b,
  input wire logic i_ready,
  input wire logic o_valid,
  input wire logic [7:0] o_data,
  input wire logic o_first,
  input wire logic o_last,
  input wire logic o_busy
);
  import ppsp_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [5:0] idx_q;
  logic take;
  assign take = i_req && !o_busy;
  // byte position of the beat on offer
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn || !o_busy)
      idx_q <= 6'h0;
    else if (o_valid && i_ready)
      idx_q <= idx_q + 6'h1;
  end
  property p_fast_a;
    take && i_buf_mode == PPSP_BUF_SW_A |=> ##1 o_data == $past(i_fast_a[7:0], 2);
  endproperty
  a_fast_a: assert property (p_fast_a) else $error("byte 0 not fast count of buffer A");
  property p_fast_b;
    take && i_buf_mode == PPSP_BUF_SW_B |=> ##1 o_data == $past(i_fast_b[7:0], 2);
  endproperty
  a_fast_b: assert property (p_fast_b) else $error("byte 0 not fast count of buffer B");
  property p_start;
    take |=> o_busy && !o_valid ##1 o_valid && o_first && idx_q == 6'h0;
  endproperty
  a_start: assert property (p_start) else $error("packet start late or malformed");
  property p_last;
    o_valid |-> o_last == (idx_q == 6'h3f);
  endproperty
  a_last: assert property (p_last) else $error("last flag not on byte 63");
  property p_first;
    o_valid |-> o_first == (idx_q == 6'h00);
  endproperty
  a_first: assert property (p_first) else $error("first flag not on byte 0");
  property p_zero;
    o_valid && (idx_q inside {6'h08, 6'h0d, [6'h12:6'h15], 6'h17, [6'h1c:6'h3f]}) |-> o_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("unused byte not zero");
  property p_ms;
    o_valid && idx_q == 6'h09 |-> o_data < 8'h64;
  endproperty
  a_ms: assert property (p_ms) else $error("millisecond byte out of range");
  property p_stand;
    o_valid && !i_ready |=> o_valid && $stable(o_data) && $stable(o_last);
  endproperty
  a_stand: assert property (p_stand) else $error("byte dropped while stalled");
  c_take_b: cover property (take && i_buf_mode == PPSP_BUF_SW_B);
  c_take_hw: cover property (take && i_buf_mode == PPSP_BUF_HW);
  c_stall: cover property (o_valid && !i_ready);
  c_end: cover property (o_last && i_ready);
endmodule : ppsp_monitor
bind ppsp_framer ppsp_monitor i_ppsp_monitor (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req(i_req),
  .i_buf_mode(i_buf_mode), .i_fast_a(i_fast_a), .i_fast_b(i_fast_b), .i_ready(i_ready), .o_valid(o_valid),
  .o_data(o_data), .o_first(o_first), .o_last(o_last), .o_busy(o_busy));

// ---- tb/ppsp_sink.sv ----
/* far-side sink model: accepts bytes, stalls at random when asked */
`timescale 1ns/100ps
module ppsp_sink (
  input wire logic i_sys_clk,
  input wire logic i_stall_en,
  output logic o_ready
);
  initial o_ready = 1'b0;
  always @(negedge i_sys_clk)
    o_ready <= !i_stall_en || ($urandom % 3 != 0);
endmodule : ppsp_sink

// ---- tb/tb_top.sv ----
/* bench: random status packets checked byte by byte against a model; uses ppsp_sink */
`timescale 1ns/100ps
module tb_top;
  import ppsp_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, req = 1'b0, hw = 1'b0, stall = 1'b0;
  ppsp_buf_mode_t mode = PPSP_BUF_SW_A;
  logic [31:0] fa = '0, sa = '0, fb = '0, sb = '0, ser = '0, gp = '0;
  logic [6:0] ms = '0;
  logic [23:0] t100 = '0;
  logic [7:0] tmp = '0, data;
  logic ready, valid, first, last, busy;
  logic [7:0] exp [64];
  int miscompares = 0;
  int compares = 0;
  initial forever #5 clk = ~clk;
  ppsp_sink i_ppsp_sink (.i_sys_clk(clk), .i_stall_en(stall), .o_ready(ready));
  ppsp_framer i_ppsp_framer (.i_sys_clk(clk), .i_rstn(rstn), .i_req(req), .i_buf_mode(mode), .i_hw_buf_sel(hw),
    .i_fast_a(fa), .i_slow_a(sa), .i_fast_b(fb), .i_slow_b(sb), .i_acc_ms(ms), .i_acc_t100(t100),
    .i_serial(ser), .i_temp(tmp), .i_gp_count(gp), .i_ready(ready), .o_valid(valid), .o_data(data),
    .o_first(first), .o_last(last), .o_busy(busy));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic scramble;
    {fa, sa, fb, sb, ser, gp, t100, tmp} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    ms = 7'($urandom % 100);
  endtask : scramble
  // one packet from an idle negedge; inputs change while busy to prove the snapshot
  task automatic packet;
    logic b;
    int n;
    b = mode == PPSP_BUF_SW_B || (mode == PPSP_BUF_HW && hw);
    exp = '{default: 8'h00};
    for (n = 0; n < 4; n++)
    begin
      exp[n] = b ? fb[8*n +: 8] : fa[8*n +: 8];
      exp[4+n] = b ? sb[8*n +: 8] : sa[8*n +: 8];
      exp[14+n] = ser[8*n +: 8];
      exp[24+n] = gp[8*n +: 8];
      exp[10+n] = (n < 3) ? t100[8*n +: 8] : 8'h00;
    end
    exp[9] = {1'b0, ms};
    exp[22] = tmp;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    scramble();
    n = 0;
    for (int w = 0; w < 2000 && n < 64; w++)
    begin
      #1;
      if (valid && ready)
      begin
        chk("data", exp[n], data);
        chk("last", 8'(n == 63), {7'h0, last});
        chk("first", 8'(n == 0), {7'h0, first});
        n++;
      end
      @(negedge clk);
    end
    chk("count", 8'h40, 8'(n));
    chk("idle", 8'h00, {6'h0, busy, valid});
  endtask : packet
  initial
  begin
    void'($urandom(32'hb704_7110));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      mode = ppsp_buf_mode_t'(m % 4);
      hw = m[2];
      stall = m[0];
      scramble();
      repeat (3) @(negedge clk);
      repeat (3) packet();
      $display("test mode %0d hw %0d done", m % 4, hw);
    end
    // reset in mid packet: outputs clear, next packet is clean
    mode = PPSP_BUF_SW_B;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk("reset flags", 8'h00, {4'h0, valid, first, last, busy});
    chk("reset data", 8'h00, data);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("release flags", 8'h00, {4'h0, valid, first, last, busy});
    repeat (2) @(negedge clk);
    packet();
    $display("test mid reset done");
    stop_test();
  end
  initial
  begin
    #400_000;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
